// ### clock_manager_pkg.sv
package clock_manager_pkg;

  localparam int MANAGER_COUNT = 4;
  localparam int SHIFT_WIDTH = 9;
  localparam int FREQ_WIDTH = 20;

  // Configured shift is a signed fraction of the period
  localparam logic signed [8:0] SHIFT_LIMIT = 9'sh0FF;
  localparam logic signed [8:0] SHIFT_RESET = 9'sh000;

  // Host step clock toggles every this many cycles
  localparam logic [3:0] STEP_CLOCK_HALF = 4'h2;

  localparam logic [19:0] FREQ_RESET = 20'h0_0000;

  typedef enum logic [1:0] {PHASE_NONE, PHASE_FIXED, PHASE_VARIABLE} phase_mode_type;
  typedef enum logic {ALIGN_SYSTEM_SYNC, ALIGN_SOURCE_SYNC} alignment_type;
  typedef enum logic {SYNTH_LOW_RANGE, SYNTH_HIGH_RANGE} synth_range_type;

endpackage

// ### clock_manager_if.sv
`timescale 1ns/100ps
interface clock_manager_if;
  import clock_manager_pkg::*;

  logic                     shiftStepEnable;
  logic                     shiftStepClock;
  logic                     shiftDirection;
  logic                     shiftDone;
  logic [MANAGER_COUNT-1:0] lockIndication;
  logic                     completionAllowed;

  modport device
  (
    input  shiftStepEnable,
    input  shiftStepClock,
    input  shiftDirection,
    output shiftDone,
    output lockIndication,
    output completionAllowed
  );

  modport host
  (
    output shiftStepEnable,
    output shiftStepClock,
    output shiftDirection,
    input  shiftDone,
    input  lockIndication,
    input  completionAllowed
  );

endinterface

// ### clock_manager_device.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module clock_manager_device
  import clock_manager_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          rstn,
  clock_manager_if.device                    link,
  input  wire phase_mode_type                phaseModeSelect,
  input  wire logic signed [SHIFT_WIDTH-1:0] configShiftValue,
  input  wire alignment_type                 alignmentOption,
  input  wire synth_range_type               synthRangeSelect,
  input  wire logic                          inputHalving,
  input  wire logic [MANAGER_COUNT-1:0]      waitForLock,
  input  wire logic [MANAGER_COUNT-1:0]      lockRaw,
  input  wire logic                          refClockIn,
  input  wire logic [FREQ_WIDTH-1:0]         refFreqKhz,
  output logic signed [SHIFT_WIDTH-1:0]      currentShift,
  output logic                               managerClock,
  output logic                               sourceSyncAlign,
  output logic                               synthHighRange,
  output logic [FREQ_WIDTH-1:0]              effectiveFreqKhz,
  output logic                               configured
);

  ////////////////////////////////////////////////////////////////////////////
  // Saturating step; limits keep the shift inside the legal window
  function automatic logic signed [SHIFT_WIDTH-1:0] stepShift
  (
    input logic signed [SHIFT_WIDTH-1:0] value,
    input logic                          up
  );
    logic signed [SHIFT_WIDTH-1:0] result;
    begin
      result = value;
      if (up && value < SHIFT_LIMIT)
      begin
        result = value + 9'sh001;
      end
      else if (!up && value > -SHIFT_LIMIT)
      begin
        result = value - 9'sh001;
      end
      return result;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  phase_mode_type             phaseMode;
  logic                       halving;
  logic [MANAGER_COUNT-1:0]   waitMask;
  logic                       refPrev;
  logic                       stepClockPrev;

  wire logic stepRise = link.shiftStepClock & ~stepClockPrev;
  wire logic refRise  = refClockIn & ~refPrev;
  wire logic stepTaken = configured & stepRise & link.shiftStepEnable;
  wire logic variableMode = (phaseMode == PHASE_VARIABLE);
  // Mode none forces zero; fixed and variable start from the configured value
  wire logic signed [SHIFT_WIDTH-1:0] startShift =
    (phaseModeSelect == PHASE_NONE) ? SHIFT_RESET : configShiftValue;
  // Managers not waiting count as locked for the gate
  wire logic gateOpen = &(lockRaw | ~waitMask);
  wire logic [FREQ_WIDTH-1:0] halvedFreq = {1'b0, refFreqKhz[FREQ_WIDTH-1:1]};
  wire logic alignSource = (alignmentOption == ALIGN_SOURCE_SYNC);
  wire logic rangeHigh   = (synthRangeSelect == SYNTH_HIGH_RANGE);
  // Mode limits are judged on the frequency the manager really sees
  wire logic [FREQ_WIDTH-1:0] next_effectiveFreqKhz = inputHalving ? halvedFreq : refFreqKhz;
  wire logic signed [SHIFT_WIDTH-1:0] steppedShift =
    stepShift(currentShift, link.shiftDirection);
  // Later steps only move the shift in variable mode
  wire logic signed [SHIFT_WIDTH-1:0] next_currentShift =
    !configured ? startShift : ((stepTaken && variableMode) ? steppedShift : currentShift);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration is captured once at the first edge after reset
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      configured <= 1'b0;
      phaseMode  <= PHASE_NONE;
      halving    <= 1'b0;
      waitMask   <= '0;
    end
    else if (!configured)
    begin
      configured <= 1'b1;
      phaseMode  <= phaseModeSelect;
      halving    <= inputHalving;
      waitMask   <= waitForLock;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fixed and none modes never move after capture
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      currentShift <= SHIFT_RESET;
    end
    else
    begin
      currentShift <= next_currentShift;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      sourceSyncAlign  <= 1'b0;
      synthHighRange   <= 1'b0;
      effectiveFreqKhz <= FREQ_RESET;
    end
    else if (!configured)
    begin
      sourceSyncAlign  <= alignSource;
      synthHighRange   <= rangeHigh;
      effectiveFreqKhz <= next_effectiveFreqKhz;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Steps outside variable mode still answer, so the host never hangs
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      stepClockPrev  <= 1'b0;
      link.shiftDone <= 1'b0;
    end
    else
    begin
      stepClockPrev  <= link.shiftStepClock;
      link.shiftDone <= stepTaken;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference must be well below clk; toggling on each rise gives 50% duty
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      refPrev      <= 1'b0;
      managerClock <= 1'b0;
    end
    else
    begin
      refPrev <= refClockIn;
      if (halving)
      begin
        managerClock <= managerClock ^ refRise;
      end
      else
      begin
        managerClock <= refClockIn;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lock is passed on untouched by the wait option
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      link.lockIndication <= '0;
    end
    else
    begin
      link.lockIndication <= lockRaw;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Completion waits only on the managers that asked for it
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      link.completionAllowed <= 1'b0;
    end
    else
    begin
      link.completionAllowed <= configured & gateOpen;
    end
  end

endmodule

// ### clock_manager_host.sv
`timescale 1ns/100ps
module clock_manager_host
  import clock_manager_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     rstn,
  clock_manager_if.host link,
  input  wire logic     configEnd,
  input  wire logic     insertLockWait,
  input  wire logic     postponeWriteEnable,
  input  wire logic     stepRequest,
  input  wire logic     stepUp,
  output logic          configDone,
  output logic          globalWriteEnable,
  output logic          stepBusy,
  output logic          stepDone
);

  typedef enum logic [2:0] {SEQ_IDLE, SEQ_LOCK_WAIT, SEQ_DONE, SEQ_WRITE_ENABLE, SEQ_RUN}
    seq_state_type;

  seq_state_type state;
  seq_state_type next_state;
  logic [3:0]    stepCount;
  logic          stepIssued;

  ////////////////////////////////////////////////////////////////////////////
  // Lock wait goes before whichever step is postponed
  wire logic waitBeforeDone  = insertLockWait & ~postponeWriteEnable;
  wire logic waitBeforeWrite = insertLockWait & postponeWriteEnable;

  always_comb
  begin
    next_state = state;
    case (state)
      SEQ_IDLE:
        if (configEnd)
        begin
          next_state = waitBeforeDone ? SEQ_LOCK_WAIT : SEQ_DONE;
        end
      SEQ_LOCK_WAIT:
        if (link.completionAllowed)
        begin
          next_state = configDone ? SEQ_WRITE_ENABLE : SEQ_DONE;
        end
      SEQ_DONE:
        next_state = waitBeforeWrite ? SEQ_LOCK_WAIT : SEQ_WRITE_ENABLE;
      SEQ_WRITE_ENABLE:
        next_state = SEQ_RUN;
      SEQ_RUN:
        next_state = SEQ_RUN;
      default:
        next_state = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state             <= SEQ_IDLE;
      configDone        <= 1'b0;
      globalWriteEnable <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (state == SEQ_DONE)
      begin
        configDone <= 1'b1;
      end
      if (state == SEQ_WRITE_ENABLE)
      begin
        globalWriteEnable <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable is raised on a falling step clock so the device sees it stable
  wire logic stepToggle = (stepCount == STEP_CLOCK_HALF - 4'h1);
  wire logic stepFall   = stepToggle & link.shiftStepClock;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      stepCount            <= 4'h0;
      link.shiftStepClock  <= 1'b0;
      link.shiftStepEnable <= 1'b0;
      link.shiftDirection  <= 1'b0;
      stepIssued           <= 1'b0;
      stepBusy             <= 1'b0;
      stepDone             <= 1'b0;
    end
    else
    begin
      stepCount <= stepToggle ? 4'h0 : stepCount + 4'h1;
      if (stepToggle)
      begin
        link.shiftStepClock <= ~link.shiftStepClock;
      end
      stepDone <= link.shiftDone;
      if (stepRequest && !stepBusy)
      begin
        stepBusy            <= 1'b1;
        link.shiftDirection <= stepUp;
      end
      if (stepFall && stepBusy && !stepIssued && globalWriteEnable)
      begin
        link.shiftStepEnable <= 1'b1;
        stepIssued           <= 1'b1;
      end
      else if (stepFall && link.shiftStepEnable)
      begin
        link.shiftStepEnable <= 1'b0;
      end
      if (link.shiftDone)
      begin
        stepBusy   <= 1'b0;
        stepIssued <= 1'b0;
      end
    end
  end

endmodule

// ### clock_manager_props.sv
`timescale 1ns/100ps
module clock_manager_props
  import clock_manager_pkg::*;
(
  input wire logic                     clk,
  input wire logic                     rstn,
  input wire logic                     shiftStepEnable,
  input wire logic                     shiftStepClock,
  input wire logic                     shiftDirection,
  input wire logic                     shiftDone,
  input wire logic [MANAGER_COUNT-1:0] lockIndication,
  input wire logic                     completionAllowed
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////
  // Step taken on a rising step clock with enable held
  sequence stepRise;
    !shiftStepClock ##1 (shiftStepClock && shiftStepEnable);
  endsequence
  a_step_answer: assert property (stepRise |=> shiftDone)
    else $error("shift done missing after step");
  a_done_cause: assert property (shiftDone |-> $past(shiftStepEnable)
    && $past(shiftStepClock) && !$past(shiftStepClock, 2))
    else $error("shift done without a step");
  a_done_pulse: assert property (shiftDone |=> !shiftDone)
    else $error("shift done longer than one cycle");
  a_done_bound: assert property ($rose(shiftStepEnable) |-> ##[1:8] shiftDone)
    else $error("no shift done after enable");
  a_enable_held: assert property ($rose(shiftStepEnable) |-> shiftStepEnable[*4])
    else $error("enable dropped inside a step period");
  a_dir_stable: assert property (shiftStepEnable && $past(shiftStepEnable)
    |-> $stable(shiftDirection))
    else $error("direction moved during a step");
  a_clock_half: assert property ($changed(shiftStepClock)
    |=> !$changed(shiftStepClock) ##1 $changed(shiftStepClock))
    else $error("step clock half period wrong");
  a_single_done: assert property (shiftDone |-> ##1 !shiftDone[*2])
    else $error("two answers for one step");
  a_lock_opens: assert property (&lockIndication && $past(&lockIndication)
    |-> completionAllowed)
    else $error("completion held although every manager locked");
  c_lock_done: cover property (completionAllowed && (&lockIndication));
endmodule

// ### tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import clock_manager_pkg::*;
  logic clk = 0, rstn = 0, refClockIn = 0, inputHalving = 0;
  logic configEnd = 0, insertLockWait = 0, postponeWriteEnable = 0;
  logic stepRequest = 0, stepUp = 0, managerClock, configured;
  logic sourceSyncAlign, synthHighRange, configDone, globalWriteEnable, stepBusy, stepDone;
  logic [3:0] waitForLock = 0, lockRaw = 0;
  logic [19:0] refFreqKhz = 0, effectiveFreqKhz;
  logic signed [8:0] configShiftValue = 0, currentShift;
  phase_mode_type phaseModeSelect = PHASE_NONE;
  alignment_type alignmentOption = ALIGN_SYSTEM_SYNC;
  synth_range_type synthRangeSelect = SYNTH_LOW_RANGE;
  int failures = 0, num_checks = 0, r, k, i, sh, e, nm, nh;
  clock_manager_if bus();
  always #25 clk = ~clk;
  // Reference slower than clk/2 so sampling sees every edge
  always #200 refClockIn = ~refClockIn;
  clock_manager_device u_clock_manager_device (.clk(clk), .rstn(rstn), .link(bus),
    .phaseModeSelect(phaseModeSelect), .configShiftValue(configShiftValue),
    .alignmentOption(alignmentOption), .synthRangeSelect(synthRangeSelect),
    .inputHalving(inputHalving), .waitForLock(waitForLock), .lockRaw(lockRaw),
    .refClockIn(refClockIn), .refFreqKhz(refFreqKhz), .currentShift(currentShift),
    .managerClock(managerClock), .sourceSyncAlign(sourceSyncAlign),
    .synthHighRange(synthHighRange), .effectiveFreqKhz(effectiveFreqKhz),
    .configured(configured));
  clock_manager_host u_clock_manager_host (.clk(clk), .rstn(rstn), .link(bus),
    .configEnd(configEnd), .insertLockWait(insertLockWait),
    .postponeWriteEnable(postponeWriteEnable), .stepRequest(stepRequest), .stepUp(stepUp),
    .configDone(configDone), .globalWriteEnable(globalWriteEnable), .stepBusy(stepBusy),
    .stepDone(stepDone));
  clock_manager_props u_clock_manager_props (.clk(clk), .rstn(rstn),
    .shiftStepEnable(bus.shiftStepEnable), .shiftStepClock(bus.shiftStepClock),
    .shiftDirection(bus.shiftDirection), .shiftDone(bus.shiftDone),
    .lockIndication(bus.lockIndication), .completionAllowed(bus.completionAllowed));
  ////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string n, input logic [19:0] x, input logic [19:0] s);
    num_checks++;
    if (s !== x)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic bound(input bit ok, input string n);
    if (!ok)
    begin
      check(n, 1, 0);
      conclude();
    end
  endtask
  // Saturating step, the shift never leaves plus or minus 255
  function automatic int nextShift(input int v, input bit up);
    v = up ? v + 1 : v - 1;
    return v > 255 ? 255 : (v < -255 ? -255 : v);
  endfunction
  initial
  begin
    void'($urandom(65));
    for (r = 0; r < 6; r++)
    begin
      rstn = 0;
      phaseModeSelect = phase_mode_type'(r < 2 ? 2 : (r < 4 ? r - 2 : $urandom_range(2)));
      sh = r == 0 ? 255 : (r == 1 ? -255 : int'($urandom_range(510)) - 255);
      configShiftValue = 9'(sh);
      alignmentOption = alignment_type'(r[0]);
      synthRangeSelect = synth_range_type'($urandom_range(1));
      inputHalving = r[1];
      refFreqKhz = 20'(24000 + $urandom_range(156000));
      waitForLock = r ? 4'($urandom) : 4'h0;
      lockRaw = r ? 4'($urandom) : 4'h0;
      insertLockWait = r != 1;
      postponeWriteEnable = r[0];
      repeat (10) @(negedge clk);
      rstn = 1;
      repeat (2) @(negedge clk);
      e = phaseModeSelect == PHASE_NONE ? 0 : sh;
      check("configured", 1, configured);
      check("shift", 20'(e), 20'(currentShift));
      check("align", alignmentOption, sourceSyncAlign);
      check("range", synthRangeSelect, synthHighRange);
      check("freq", inputHalving ? refFreqKhz >> 1 : refFreqKhz, effectiveFreqKhz);
      check("lock", lockRaw, bus.lockIndication);
      check("allowed", &(lockRaw | ~waitForLock), bus.completionAllowed);
      nm = 0;
      nh = 0;
      for (i = 0; i < 64; i++)
      begin
        k = managerClock;
        @(negedge clk);
        nm += int'(managerClock != k);
        nh += int'(managerClock === 1'b1);
      end
      k = inputHalving ? 8 : 16;
      check("manager edges", k, (nm >= k - 1 && nm <= k + 1) ? k : nm);
      check("manager duty", 32, (nh >= 30 && nh <= 34) ? 32 : nh);
      configEnd = 1;
      @(negedge clk);
      configEnd = 0;
      if (insertLockWait && !(&(lockRaw | ~waitForLock)))
      begin
        repeat (8) @(negedge clk);
        check("held write enable", 0, globalWriteEnable);
        check("held done", postponeWriteEnable, configDone);
        lockRaw = 4'hF;
      end
      for (i = 0; i < 40 && globalWriteEnable !== 1'b1; i++) @(negedge clk);
      bound(globalWriteEnable === 1'b1, "write enable");
      check("done", 1, configDone);
      for (k = 0; k < 4; k++)
      begin
        stepUp = r == 0 ? 1 : (r == 1 ? 0 : $urandom_range(1));
        stepRequest = 1;
        @(negedge clk);
        stepRequest = 0;
        check("busy", 1, stepBusy);
        for (i = 0; i < 40 && stepDone !== 1'b1; i++) @(negedge clk);
        bound(stepDone === 1'b1, "step done");
        check("busy idle", 0, stepBusy);
        if (phaseModeSelect == PHASE_VARIABLE)
          e = nextShift(e, stepUp);
        check("stepped shift", 20'(e), 20'(currentShift));
        repeat (6) @(negedge clk);
      end
    end
    conclude();
  end
endmodule
